// *** hdl/sapm_pkg.sv ***
// Shared constants and types for the serial audio pin mapping block
package sapm_pkg;
  // Pin mode encodings for each lane and fast clock pin
  typedef enum logic [1:0] {
    SAPM_PIN_OFF = 2'b00,
    SAPM_PIN_IN = 2'b01,
    SAPM_PIN_OUT = 2'b10,
    SAPM_PIN_FUNC = 2'b11
  } sapm_mode_t;
  localparam sapm_mode_t SAPM_MODE_RST = SAPM_PIN_OFF;
  localparam int SAPM_WORD_W = 24;
  localparam int SAPM_FIFO_D = 8;
  localparam int SAPM_CNT_W = 5;
  localparam logic [4:0] SAPM_LAST_BIT = 5'h17;
  localparam logic [7:0] SAPM_FAST_DIV = 8'h02;
  localparam int SAPM_PTR_W = 3;
endpackage

// *** hdl/sapm_fifo_if.sv ***
// Valid/ready carrier between the receive shifter and its FIFO
`timescale 1ns/1ps
interface sapm_fifo_if #(parameter int W = 24);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// *** hdl/sapm_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module sapm_fifo #(
  parameter int W = 24,
  parameter int D = 8,
  parameter int AW = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Fill side
  sapm_fifo_if.dst wr,
  // Drain side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_r [D];
  logic [AW:0] wp_r;
  logic [AW:0] rp_r;
  logic full;
  logic empty;
  // Pointers carry one extra wrap bit for honest full/empty
  assign empty = (wp_r == rp_r);
  assign full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
  assign wr.ready = !full;
  // Write side
  always_ff @(posedge clk) begin
    if (rst) begin
      wp_r <= '0;
    end else if (wr.valid && !full) begin
      mem_r[wp_r[AW-1:0]] <= wr.data;
      wp_r <= wp_r + 1'b1;
    end
  end
  // Read side: data held in a register, advanced on handshake
  always_ff @(posedge clk) begin
    if (rst) begin
      rp_r <= '0;
      rd_valid <= 1'b0;
      rd_data <= '0;
    end else if (!rd_valid || rd_ready) begin
      rd_valid <= !empty;
      if (!empty) begin
        rd_data <= mem_r[rp_r[AW-1:0]];
        rp_r <= rp_r + 1'b1;
      end
    end
  end
endmodule

// *** hdl/sapm_top.sv ***
// Pin mapping of two serial audio units: lanes, port bits, fast clocks
//
// Summary of operation
// [R1] Lane two, as transmitter, shifts out of transmit shifter two.
// [R2] Lane three, as receiver, shifts sampled bits into receive shifter three.
// [R3] Lane one in function mode always drives from transmit shifter one.
// [R4] Lane zero in function mode always drives from transmit shifter zero.
// [R5] Unit a port pins each set as input, output or disconnected.
// [R6] Unit b port pins each set as input or disconnected; output mode drives the sample clock, not port_e_out.
// [R7] Reset puts every shared pin in disconnected port state.
// [R8] Receiver fast clock pin in function mode clocks unit b receiver.
// [R9] Receiver fast clock pin as output drives a sample clock.
// [R10] Transmitter fast clock pin in function mode clocks unit b transmitter.
// [R11] Transmitter fast clock pin as output drives a sample clock.
// [R12] Transmit frame sync direction follows the sync direction bit.
// [R13] Disconnected pin: driver off, input ignored.
`timescale 1ns/1ps
module sapm_top
  import sapm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Pin modes, lanes 0..3 of unit a, then unit b fast clocks and sync
  input wire logic [1:0] mode_lane_zero,
  input wire logic [1:0] mode_lane_one,
  input wire logic [1:0] mode_lane_two,
  input wire logic [1:0] mode_lane_three,
  input wire logic [1:0] mode_rx_fast,
  input wire logic [1:0] mode_tx_fast,
  input wire logic mode_sync_pin_on,
  input wire logic transmit_sync_direction_bit,
  // Port output values and read-back
  input wire logic [3:0] port_c_out,
  input wire logic [1:0] port_e_out,
  output logic [3:0] port_c_in,
  output logic [1:0] port_e_in,
  // Serial bit timing and transmit words
  input wire logic bit_tick,
  input wire logic [23:0] tx_word_zero,
  input wire logic [23:0] tx_word_one,
  input wire logic [23:0] tx_word_two,
  input wire logic tx_sync_int,
  // Received words out
  output logic rx_valid,
  input wire logic rx_ready,
  output logic [23:0] rx_word,
  output logic rx_overrun,
  // Clock edges that unit b uses
  output logic rx_clk_edge,
  output logic tx_clk_edge,
  // Lane pins 0..3: input, output, enable
  input wire logic [3:0] lane_i,
  output logic [3:0] lane_o,
  output logic [3:0] lane_oe,
  // Fast clock pins (0 receiver, 1 transmitter) and frame sync
  input wire logic [1:0] fast_i,
  output logic [1:0] fast_o,
  output logic [1:0] fast_oe,
  input wire logic sync_i,
  output logic sync_o,
  output logic sync_oe,
  output logic sync_in
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [6:0] meta_r;
  logic [6:0] pin_r;
  logic [1:0] fast_d_r;
  // Two flops before any logic looks at a pin
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      pin_r <= '0;
    end else begin
      meta_r <= {sync_i, fast_i, lane_i};
      pin_r <= meta_r;
    end
  end

  function automatic logic is_mode(input logic [1:0] m, input sapm_mode_t v);
    return m == v;
  endfunction

  // ----------------------------------------------------------------
  // Port bit read-back
  // ----------------------------------------------------------------
  // A disconnected pin reads zero so it cannot disturb port logic
  always_ff @(posedge clk) begin
    if (rst) begin
      port_c_in <= '0;
      port_e_in <= '0;
    end else begin
      port_c_in[0] <= is_mode(mode_lane_zero, SAPM_PIN_IN) & pin_r[0]; // see [R5] [R13]
      port_c_in[1] <= is_mode(mode_lane_one, SAPM_PIN_IN) & pin_r[1]; // see [R5]
      port_c_in[2] <= is_mode(mode_lane_two, SAPM_PIN_IN) & pin_r[2]; // see [R5]
      port_c_in[3] <= is_mode(mode_lane_three, SAPM_PIN_IN) & pin_r[3]; // see [R5]
      port_e_in[0] <= is_mode(mode_rx_fast, SAPM_PIN_IN) & pin_r[4]; // see [R6] [R13]
      port_e_in[1] <= is_mode(mode_tx_fast, SAPM_PIN_IN) & pin_r[5]; // see [R6]
    end
  end

  // ----------------------------------------------------------------
  // Transmit shifters for lanes 0, 1, 2
  // ----------------------------------------------------------------
  logic [23:0] sh0_r;
  logic [23:0] sh1_r;
  logic [23:0] sh2_r;
  // Reload on frame sync, else shift MSB first on each bit tick
  always_ff @(posedge clk) begin
    if (rst) begin
      sh0_r <= '0;
      sh1_r <= '0;
      sh2_r <= '0;
    end else if (tx_sync_int) begin
      sh0_r <= tx_word_zero; // see [R4]
      sh1_r <= tx_word_one; // see [R3]
      sh2_r <= tx_word_two; // see [R1]
    end else if (bit_tick) begin
      sh0_r <= {sh0_r[22:0], 1'b0};
      sh1_r <= {sh1_r[22:0], 1'b0};
      sh2_r <= {sh2_r[22:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // Lane pin drivers
  // ----------------------------------------------------------------
  // Lanes 0, 1 and 2 have no receive option; FUNC means transmit
  always_ff @(posedge clk) begin
    if (rst) begin
      lane_o <= '0;
      lane_oe <= '0; // see [R7]
    end else begin
      lane_oe[0] <= is_mode(mode_lane_zero, SAPM_PIN_FUNC) |
                    is_mode(mode_lane_zero, SAPM_PIN_OUT); // see [R4] [R13]
      lane_o[0] <= is_mode(mode_lane_zero, SAPM_PIN_FUNC) ? sh0_r[23]
                                                          : port_c_out[0];
      lane_oe[1] <= is_mode(mode_lane_one, SAPM_PIN_FUNC) |
                    is_mode(mode_lane_one, SAPM_PIN_OUT); // see [R3]
      lane_o[1] <= is_mode(mode_lane_one, SAPM_PIN_FUNC) ? sh1_r[23]
                                                         : port_c_out[1];
      lane_oe[2] <= is_mode(mode_lane_two, SAPM_PIN_FUNC) |
                    is_mode(mode_lane_two, SAPM_PIN_OUT); // see [R1]
      lane_o[2] <= is_mode(mode_lane_two, SAPM_PIN_FUNC) ? sh2_r[23]
                                                         : port_c_out[2];
      // Lane three is a receiver in function mode, so only port drives
      lane_oe[3] <= is_mode(mode_lane_three, SAPM_PIN_OUT); // see [R2]
      lane_o[3] <= port_c_out[3];
    end
  end

  // ----------------------------------------------------------------
  // Receive shifter three and its FIFO
  // ----------------------------------------------------------------
  logic [23:0] rsh_r;
  logic [4:0] rcnt_r;
  logic rx_on;
  sapm_fifo_if #(.W(SAPM_WORD_W)) rxq ();
  assign rx_on = is_mode(mode_lane_three, SAPM_PIN_FUNC);
  // Word pushed after the last bit; a full FIFO drops it and flags
  always_ff @(posedge clk) begin
    if (rst || !rx_on || tx_sync_int) begin
      rsh_r <= '0;
      rcnt_r <= '0;
      rxq.valid <= 1'b0;
    end else begin
      // Push lasts one cycle: a full FIFO loses the word, no late write
      rxq.valid <= 1'b0;
      if (bit_tick) begin
        rsh_r <= {rsh_r[22:0], pin_r[3]}; // see [R2] [R13]
        if (rcnt_r == SAPM_LAST_BIT) begin
          rcnt_r <= '0;
          rxq.valid <= 1'b1;
        end else begin
          rcnt_r <= rcnt_r + 1'b1;
        end
      end
    end
  end
  assign rxq.data = rsh_r;
  // Overrun is sticky until reset so lost words are never hidden
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_overrun <= 1'b0;
    end else if (rxq.valid && !rxq.ready) begin
      rx_overrun <= 1'b1;
    end
  end
  sapm_fifo #(.W(SAPM_WORD_W), .D(SAPM_FIFO_D), .AW(SAPM_PTR_W)) u_fifo (
    .clk(clk),
    .rst(rst),
    .wr(rxq.dst),
    .rd_valid(rx_valid),
    .rd_ready(rx_ready),
    .rd_data(rx_word)
  );

  // ----------------------------------------------------------------
  // Fast clock pins of unit b
  // ----------------------------------------------------------------
  logic [7:0] div_r;
  logic fclk_r;
  // Divider gives the outgoing sample clock
  always_ff @(posedge clk) begin
    if (rst) begin
      div_r <= '0;
      fclk_r <= 1'b0;
    end else if (div_r == SAPM_FAST_DIV - 8'h01) begin
      div_r <= '0;
      fclk_r <= ~fclk_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end
  // Edges of an incoming clock replace the core clock ticks
  always_ff @(posedge clk) begin
    if (rst) begin
      fast_d_r <= '0;
      rx_clk_edge <= 1'b0;
      tx_clk_edge <= 1'b0;
      fast_o <= '0;
      fast_oe <= '0;
    end else begin
      fast_d_r <= pin_r[5:4];
      rx_clk_edge <= is_mode(mode_rx_fast, SAPM_PIN_FUNC)
        ? (pin_r[4] & ~fast_d_r[0]) : 1'b1; // see [R8]
      tx_clk_edge <= is_mode(mode_tx_fast, SAPM_PIN_FUNC)
        ? (pin_r[5] & ~fast_d_r[1]) : 1'b1; // see [R10]
      fast_oe[0] <= is_mode(mode_rx_fast, SAPM_PIN_OUT); // see [R9] [R13]
      fast_o[0] <= fclk_r; // see [R9]
      fast_oe[1] <= is_mode(mode_tx_fast, SAPM_PIN_OUT); // see [R11]
      fast_o[1] <= fclk_r; // see [R11]
    end
  end

  // ----------------------------------------------------------------
  // Transmit frame sync pin
  // ----------------------------------------------------------------
  // Shared by transmitters and receivers in synchronous operation
  always_ff @(posedge clk) begin
    if (rst) begin
      sync_o <= 1'b0;
      sync_oe <= 1'b0;
      sync_in <= 1'b0;
    end else begin
      sync_oe <= mode_sync_pin_on & transmit_sync_direction_bit; // see [R12]
      sync_o <= tx_sync_int;
      sync_in <= mode_sync_pin_on & ~transmit_sync_direction_bit
                 & pin_r[6]; // see [R12] [R13]
    end
  end
endmodule

// *** dv/sapm_asserts.sv ***
// Checker for the pin mapping behaviour at the top module's ports
`timescale 1ns/1ps
module sapm_asserts
  import sapm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched ports
  input wire logic [1:0] mode_lane_zero,
  input wire logic [1:0] mode_lane_one,
  input wire logic [1:0] mode_lane_two,
  input wire logic [1:0] mode_rx_fast,
  input wire logic mode_sync_pin_on,
  input wire logic transmit_sync_direction_bit,
  input wire logic [3:0] port_c_out,
  input wire logic [23:0] tx_word_two,
  input wire logic tx_sync_int,
  input wire logic rx_clk_edge,
  input wire logic [3:0] lane_o,
  input wire logic [3:0] lane_oe,
  input wire logic [1:0] fast_o,
  input wire logic [1:0] fast_oe,
  input wire logic sync_oe
);
  // ----------
  // Properties
  // ----------
  logic [1:0] up_r;
  // Skip the edges where outputs still show reset
  always_ff @(posedge clk) begin
    if (rst) up_r <= 2'h0;
    else if (up_r != 2'h3) up_r <= up_r + 2'h1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || up_r != 2'h3);
  sequence s_fast_out;
    (mode_rx_fast == SAPM_PIN_OUT) [*6];
  endsequence
  sequence s_core_clk;
    (mode_rx_fast != SAPM_PIN_FUNC) [*2];
  endsequence
  // Load edge, then one more cycle in function mode before the pin shows it
  sequence s_load_two;
    tx_sync_int && mode_lane_two == SAPM_PIN_FUNC
    ##1 mode_lane_two == SAPM_PIN_FUNC;
  endsequence
  a_reset_pins_off: assert property (disable iff (1'b0)
    rst |=> lane_oe == 4'h0 && fast_oe == 2'h0 && !sync_oe)
    else $error("pin driven after reset");
  a_lane_two_load: assert property (
    s_load_two |=> lane_oe[2] && lane_o[2] == $past(tx_word_two[23], 2))
    else $error("lane two missed the loaded msb");
  a_lane_one_tx: assert property (
    mode_lane_one == SAPM_PIN_FUNC |=> lane_oe[1])
    else $error("lane one not driven");
  a_lane_zero_tx: assert property (
    mode_lane_zero == SAPM_PIN_FUNC |=> lane_oe[0])
    else $error("lane zero not driven");
  a_port_out_value: assert property (
    mode_lane_two == SAPM_PIN_OUT
    |=> lane_oe[2] && lane_o[2] == $past(port_c_out[2]))
    else $error("port bit not driven out");
  a_fast_clk_out: assert property (
    s_fast_out |-> fast_oe[0] && fast_o[0] != $past(fast_o[0], 2))
    else $error("fast clock output not at a quarter rate");
  a_core_edge_rx: assert property (
    s_core_clk |-> rx_clk_edge)
    else $error("receiver lost the core clock");
  a_sync_dir: assert property (
    mode_sync_pin_on |=> sync_oe == $past(transmit_sync_direction_bit))
    else $error("sync pin direction wrong");
endmodule
bind sapm_top sapm_asserts chk_u (.clk(clk), .rst(rst),
  .mode_lane_zero(mode_lane_zero), .mode_lane_one(mode_lane_one),
  .mode_lane_two(mode_lane_two), .mode_rx_fast(mode_rx_fast),
  .mode_sync_pin_on(mode_sync_pin_on), .port_c_out(port_c_out),
  .transmit_sync_direction_bit(transmit_sync_direction_bit),
  .tx_word_two(tx_word_two), .tx_sync_int(tx_sync_int),
  .rx_clk_edge(rx_clk_edge), .lane_o(lane_o), .lane_oe(lane_oe),
  .fast_o(fast_o), .fast_oe(fast_oe), .sync_oe(sync_oe));

// *** dv/sapm_codec.sv ***
// Model of the external converter: serial word source and fast clock
`timescale 1ns/1ps
module sapm_codec_model (
  // Serial word source
  input wire logic clk,
  input wire logic load,
  input wire logic [23:0] word,
  input wire logic step,
  output logic sdata,
  // Fast clock source
  input wire logic run,
  output logic hclk = 1'b0
);
  logic [23:0] sh_r = 24'h0;
  int left = 0;
  // MSB first; once the word is out the line wanders every cycle
  always @(posedge clk) begin
    if (load) begin
      sh_r <= word;
      left <= 24;
    end else if (left == 0) sh_r <= ~sh_r;
    else if (step) begin
      sh_r <= sh_r << 1;
      left <= left - 1;
    end
  end
  assign sdata = sh_r[23];
  // Fast clock stands still unless asked to run
  always #80 if (run) hclk = ~hclk;
endmodule

// *** dv/sapm_top_test.sv ***
// Self-checking bench for the serial audio pin mapping block
`timescale 1ns/1ps
module sapm_top_test;
  import sapm_pkg::*;
  logic clk = 0, rst = 1, sync_on = 0, sdir = 0, tick = 0, tsync = 0;
  logic rx_ready = 0, ld = 0, stp = 0, run = 0, cod = 0, xs = 0;
  logic [1:0] m [0:5];
  logic [23:0] tw [0:2];
  logic [23:0] rw [0:9];
  logic [3:0] pco = 4'h0, ext = 4'h0, pci, lo, loe, li;
  logic [1:0] peo = 2'h0, fext = 2'h0, pei, fo, foe, fi;
  logic [23:0] cw = 24'h0, rxw;
  logic rxv, ovr, rce, tce, so, soe, si, sd, hclk, sin;
  int failures = 0, n_checks = 0, cnt;
  // Wire levels: whoever has its enable up owns the pin
  assign li = (loe & lo) | (~loe & {cod ? sd : ext[3], ext[2:0]});
  // Fast pins idle at a random level while the converter clock is stopped
  assign fi = (foe & fo) | (~foe & (run ? {hclk, hclk} : fext));
  assign si = soe ? so : xs;
  always #5 clk = ~clk;
  sapm_top dut_u (.clk(clk), .rst(rst), .mode_lane_zero(m[0]),
    .mode_lane_one(m[1]), .mode_lane_two(m[2]), .mode_lane_three(m[3]),
    .mode_rx_fast(m[4]), .mode_tx_fast(m[5]), .mode_sync_pin_on(sync_on),
    .transmit_sync_direction_bit(sdir), .port_c_out(pco), .port_e_out(peo),
    .port_c_in(pci), .port_e_in(pei), .bit_tick(tick), .tx_word_zero(tw[0]),
    .tx_word_one(tw[1]), .tx_word_two(tw[2]), .tx_sync_int(tsync),
    .rx_valid(rxv), .rx_ready(rx_ready), .rx_word(rxw), .rx_overrun(ovr),
    .rx_clk_edge(rce), .tx_clk_edge(tce), .lane_i(li), .lane_o(lo),
    .lane_oe(loe), .fast_i(fi), .fast_o(fo), .fast_oe(foe), .sync_i(si),
    .sync_o(so), .sync_oe(soe), .sync_in(sin));
  sapm_codec_model cod_u (.clk(clk), .load(ld), .word(cw), .step(stp),
    .sdata(sd), .run(run), .hclk(hclk));
  // -------------
  // Check helpers
  // -------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Port read-back only passes the pin in input mode
  function automatic logic pin_in(logic [1:0] md, logic v);
    return (md == SAPM_PIN_IN) ? v : 1'b0;
  endfunction
  // Port output: enable and the level it puts on the pin
  function automatic logic [1:0] pin_out(logic [1:0] md, logic v);
    return {md == SAPM_PIN_OUT, (md == SAPM_PIN_OUT) & v};
  endfunction
  // Cuts a hang short
  initial begin
    #400000;
    failures++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 6; i++) m[i] = 2'h0;
    for (int i = 0; i < 3; i++) tw[i] = 24'h0;
    void'($urandom(98));
    cyc(4);
    rst <= 1'b0;
    cyc(2);
    check({loe, foe, soe, pci, pei}, 13'h0);
    // Random port modes, values and sync direction
    repeat (16) begin
      @(posedge clk);
      for (int i = 0; i < 6; i++) m[i] <= 2'($urandom_range(2));
      {pco, ext, peo, fext, sync_on, sdir, xs} <= 15'($urandom);
      cyc(5);
      #1;
      for (int i = 0; i < 4; i++) begin
        check({loe[i], lo[i] & loe[i]}, pin_out(m[i], pco[i]));
        check(pci[i], pin_in(m[i], ext[i]));
      end
      for (int j = 0; j < 2; j++) begin
        check(foe[j], m[4+j] == SAPM_PIN_OUT);
        check(pei[j], pin_in(m[4+j], fext[j]));
      end
      check(soe, sync_on & sdir);
      check(sin, sync_on & ~sdir & xs);
    end
    // Transmit lanes shift their words out MSB first
    @(posedge clk);
    for (int i = 0; i < 4; i++) m[i] <= (i < 3) ? SAPM_PIN_FUNC : SAPM_PIN_OFF;
    for (int i = 0; i < 3; i++) tw[i] <= 24'($urandom);
    @(posedge clk);
    tsync <= 1'b1;
    @(posedge clk);
    tsync <= 1'b0;
    #1 check(so, 1'b1);
    for (int k = 23; k >= 0; k--) begin
      // The pin shows a bit one clock after the shifter holds it
      @(posedge clk);
      #1;
      check(loe[2:0], 3'h7);
      check(lo[2:0], {tw[2][k], tw[1][k], tw[0][k]});
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    // Ten words: eight fill the buffer, one waits in its output register,
    // the tenth is dropped with an overrun; then drain the nine
    m[3] <= SAPM_PIN_FUNC;
    cod <= 1'b1;
    tsync <= 1'b1;
    @(posedge clk);
    tsync <= 1'b0;
    for (int w = 0; w < 10; w++) begin
      rw[w] = 24'($urandom);
      @(posedge clk);
      cw <= rw[w];
      ld <= 1'b1;
      @(posedge clk);
      ld <= 1'b0;
      repeat (24) begin
        cyc(3);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
      end
    end
    cyc(6);
    #1;
    check({rxv, ovr}, 2'h3);
    for (int w = 0; w < 9; w++) begin
      check(rxw, rw[w]);
      @(posedge clk);
      rx_ready <= 1'b1;
      @(posedge clk);
      rx_ready <= 1'b0;
      cyc(3);
      #1;
    end
    check(rxv, 1'b0);
    // Fast clock pins: drive out, then bring a clock in
    for (int j = 0; j < 2; j++) begin
      @(posedge clk);
      m[4+j] <= SAPM_PIN_OUT;
      cyc(9);
      check(foe[j], 1'b1);
      m[4+j] <= SAPM_PIN_FUNC;
      run <= 1'b1;
      // Let the old output level and the clock's start settle first
      cyc(12);
      cnt = 0;
      repeat (160) begin
        @(posedge clk);
        #1 cnt += j ? tce : rce;
      end
      check(cnt inside {[9:11]}, 1'b1);
      run <= 1'b0;
      m[4+j] <= SAPM_PIN_OFF;
    end
    cyc(4);
    tally_and_finish();
  end
endmodule
